// ---- rtl/artwo_timer.sv ----
// timer two: 16-bit auto-reload counter or two 8-bit auto-reload counters
// assumes a core special function register port, single cycle strobes
//
// Notes on behaviour
// [RL1] unsplit: 16-bit up count, wrap loads reload word, sets high flag
// [RL2] unsplit: interrupt on each overflow when global timer enable set
// [RL3] unsplit: low-byte wrap also interrupts when low enable set
// [RL4] split: two 8-bit counters, each reloaded from its own byte
// [RL5] run gates whole counter unsplit; only high byte when split
// [RL6] high byte clock: system_clock, system_clock/12 or external/8 by selects
// [RL7] low byte clock chosen alike with its own select bit
// [RL8] external divided-by-8 source synchronised to system_clock
// [RL9] split: each byte wrap sets its own overflow flag
// [RL10] split: high wrap interrupts; low wrap too when low enable set
// [RL11] flags cleared only by software writing zero
// [RL12] low flag set on every low-byte wrap in either mode
// [RL13] control bits 4 and 1 read zero, writes ignored
// [RL14] control layout 7 hi flag,6 lo flag,5 lo en,3 split,2 run,0 ext
// [RL15] run clear stops counting, except the low byte in split mode; set lets it count
// [RL16] software should keep low enable clear in 16-bit mode
// [RL17] service software reads both flags to find source, clears them
// [RL18] reload low, reload high, count low registers reset to zero
// [RL19] count high register reset zero, upper half or high counter
// [RL20] each counter steps by one per single-cycle tick
`timescale 1ns/100ps
module artwo_timer (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       high_byte_system_clock_select,
	input  wire logic       low_byte_system_clock_select,
	input  wire logic       global_timer_irq_enable,
	input  wire logic       ext_clk,
	output logic            irq
);
	import artwo_pkg::*;

	localparam int PW = $clog2(SYSTEM_CLOCK_DIVIDE);
	localparam logic [PW-1:0] PRE_LAST = PW'(SYSTEM_CLOCK_DIVIDE - 1);

	logic [7:0]    control_reg;
	logic [7:0]    reload_low_reg;
	logic [7:0]    reload_high_reg;
	logic [7:0]    count_low_reg;
	logic [7:0]    count_high_reg;
	logic [PW-1:0] pre_reg;
	logic          div12_tick;
	logic          ext_tick;

	logic       high_flag;
	logic       low_flag;
	logic       low_irq_en;
	logic       split_mode_select;
	logic       run_control;
	logic       external_clock_select;
	artwo_src_t src_high;
	artwo_src_t src_low;
	logic       tick_high;
	logic       tick_low;
	logic       step_low;
	logic       step_high;
	logic       wrap_low;
	logic       wrap_high;
	logic       wr_control;
	logic       wr_rl_low;
	logic       wr_rl_high;
	logic       wr_cnt_low;
	logic       wr_cnt_high;
	logic [7:0] control_next;
	logic [7:0] count_low_next;
	logic [7:0] count_high_next;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// choose the count source from the two select bits
	function automatic artwo_src_t pick_src(input logic sys_sel,
	                                        input logic ext_sel);
		if (sys_sel)
			pick_src = ARTWO_SRC_SYSTEM_CLOCK;
		else if (ext_sel)
			pick_src = ARTWO_SRC_EXT8;
		else
			pick_src = ARTWO_SRC_DIV12;
	endfunction : pick_src

	// tick for a chosen source
	function automatic logic src_tick(input artwo_src_t src,
	                                  input logic t12,
	                                  input logic t8);
		unique case (src)
			ARTWO_SRC_SYSTEM_CLOCK: src_tick = 1'b1;
			ARTWO_SRC_DIV12:  src_tick = t12;
			ARTWO_SRC_EXT8:   src_tick = t8;
			default:          src_tick = 1'b0;
		endcase
	endfunction : src_tick

	// ----------------------------------------
	// count sources
	// ----------------------------------------
	artwo_ext_tick #(
		.DIVIDE(EXTCLK_DIVIDE)
	) u_ext_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clk_en  (clk_en),
		.ext_clk (ext_clk),
		.ext_tick(ext_tick)
	);

	// free-running divide-by-12 prescaler
	always_ff @(posedge clk_sys) begin
		if (rst)
			pre_reg <= '0;
		else if (clk_en)
			pre_reg <= (pre_reg == PRE_LAST) ? '0 : pre_reg + 1'b1;
	end
	assign div12_tick = (pre_reg == PRE_LAST);

	// ----------------------------------------
	// control fields and clock selection
	// ----------------------------------------
	assign high_flag             = control_reg[BIT_HIGH_FLAG]; // RL14
	assign low_flag              = control_reg[BIT_LOW_FLAG];
	assign low_irq_en            = control_reg[BIT_LOW_IRQ_EN];
	assign split_mode_select     = control_reg[BIT_SPLIT];
	assign run_control           = control_reg[BIT_RUN];
	assign external_clock_select = control_reg[BIT_EXT_CLK];

	// in 16-bit mode the low select drives the whole counter
	assign src_low  = pick_src(low_byte_system_clock_select,
	                           external_clock_select); // RL7
	assign src_high = pick_src(high_byte_system_clock_select,
	                           external_clock_select); // RL6
	assign tick_low  = src_tick(src_low, div12_tick, ext_tick); // RL20
	assign tick_high = src_tick(src_high, div12_tick, ext_tick);

	// ----------------------------------------
	// count enables and wraps
	// ----------------------------------------
	// low byte free-runs in split mode, gated by run otherwise
	assign step_low  = tick_low &
	                   (split_mode_select | run_control); // RL5 RL15
	assign step_high = split_mode_select ?
	                   (tick_high & run_control) :          // RL5
	                   (step_low && count_low_reg == BYTE_ALL_ONES); // RL1
	assign wrap_low  = step_low  && count_low_reg  == BYTE_ALL_ONES;
	assign wrap_high = step_high && count_high_reg == BYTE_ALL_ONES;

	// next count values, reload on wrap
	always_comb begin
		count_low_next  = count_low_reg + 8'h01;
		count_high_next = count_high_reg + 8'h01;
		if (split_mode_select) begin
			if (wrap_low)
				count_low_next = reload_low_reg; // RL4
			if (wrap_high)
				count_high_next = reload_high_reg; // RL4
		end else if (wrap_high) begin
			count_low_next  = reload_low_reg; // RL1
			count_high_next = reload_high_reg; // RL1
		end
	end

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	assign wr_control  = sfr_wr && sfr_addr == ADDR_CONTROL;
	assign wr_rl_low   = sfr_wr && sfr_addr == ADDR_RELOAD_LOW;
	assign wr_rl_high  = sfr_wr && sfr_addr == ADDR_RELOAD_HIGH;
	assign wr_cnt_low  = sfr_wr && sfr_addr == ADDR_COUNT_LOW;
	assign wr_cnt_high = sfr_wr && sfr_addr == ADDR_COUNT_HIGH;

	// control write, then hardware flag sets win over clears
	always_comb begin
		control_next = control_reg;
		if (wr_control)
			control_next = sfr_wdata & CONTROL_WRITE_MASK; // RL13 RL11
		if (wrap_high)
			control_next[BIT_HIGH_FLAG] = 1'b1; // RL1 RL9
		if (wrap_low)
			control_next[BIT_LOW_FLAG] = 1'b1; // RL9 RL12
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// control and reload bytes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			control_reg     <= RESET_BYTE; // RL14
			reload_low_reg  <= RESET_BYTE; // RL18
			reload_high_reg <= RESET_BYTE; // RL18
		end else if (clk_en) begin
			control_reg <= control_next;
			if (wr_rl_low)
				reload_low_reg <= sfr_wdata;
			if (wr_rl_high)
				reload_high_reg <= sfr_wdata;
		end
	end

	// count bytes; a software write takes precedence over a step
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_low_reg  <= RESET_BYTE; // RL18
			count_high_reg <= RESET_BYTE; // RL19
		end else if (clk_en) begin
			if (wr_cnt_low)
				count_low_reg <= sfr_wdata;
			else if (step_low || (wrap_high && !split_mode_select))
				count_low_reg <= count_low_next;
			if (wr_cnt_high)
				count_high_reg <= sfr_wdata;
			else if (step_high)
				count_high_reg <= count_high_next; // RL20
		end
	end

	// ----------------------------------------
	// read data and interrupt
	// ----------------------------------------
	// registered read data from the addressed register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sfr_rdata <= RESET_BYTE;
		end else if (clk_en) begin
			unique case (sfr_addr)
				ADDR_CONTROL:     sfr_rdata <= control_reg; // RL13
				ADDR_RELOAD_LOW:  sfr_rdata <= reload_low_reg;
				ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_reg;
				ADDR_COUNT_LOW:   sfr_rdata <= count_low_reg;
				ADDR_COUNT_HIGH:  sfr_rdata <= count_high_reg;
				default:          sfr_rdata <= RESET_BYTE;
			endcase
		end
	end

	// request held while high flag, or low flag with low enable set, is pending; same in both modes
	assign irq = global_timer_irq_enable &
	             (high_flag | (low_irq_en & low_flag)); // RL2 RL3 RL10

endmodule : artwo_timer

// ---- common/artwo_pkg.sv ----
// package of constants for the auto-reload timer two block
// assumes an 8-bit special function register port driven by the core
package artwo_pkg;
	// register addresses on the special function register port
	localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
	localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hcd;

	// control register field positions
	localparam int BIT_HIGH_FLAG  = 7;
	localparam int BIT_LOW_FLAG   = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_SPLIT      = 3;
	localparam int BIT_RUN        = 2;
	localparam int BIT_EXT_CLK    = 0;

	// writable control bits, bits 4 and 1 excluded
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hed;
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam logic [7:0] BYTE_ALL_ONES      = 8'hff;

	// prescaler ratios
	localparam int SYSTEM_CLOCK_DIVIDE = 12;
	localparam int EXTCLK_DIVIDE = 8;

	// count source selection
	typedef enum logic [2:0] {
		ARTWO_SRC_SYSTEM_CLOCK = 3'b001,
		ARTWO_SRC_DIV12  = 3'b010,
		ARTWO_SRC_EXT8   = 3'b100
	} artwo_src_t;
endpackage : artwo_pkg

// ---- rtl/artwo_ext_tick.sv ----
// synchroniser and divide-by-8 for the external oscillator count source
// assumes ext_clk is a slow level sampled on clk_sys
`timescale 1ns/100ps
module artwo_ext_tick #(
	parameter int DIVIDE = artwo_pkg::EXTCLK_DIVIDE
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic ext_clk,
	output logic      ext_tick
);
	import artwo_pkg::*;

	localparam int CW = $clog2(DIVIDE);
	localparam logic [CW-1:0] DIV_LAST = CW'(DIVIDE - 1);

	logic          sync1_reg;
	logic          sync2_reg;
	logic          sync3_reg;
	logic [CW-1:0] div_reg;
	logic          rise;

	// ----------------------------------------
	// synchroniser and edge divider
	// ----------------------------------------
	assign rise = sync2_reg & ~sync3_reg;

	// two-stage synchroniser, then edge detect on stage two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			div_reg   <= '0;
			ext_tick  <= 1'b0;
		end else if (clk_en) begin
			sync1_reg <= ext_clk;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			ext_tick  <= rise && (div_reg == DIV_LAST); // RL8
			if (rise) begin
				div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
			end
		end
	end
endmodule : artwo_ext_tick

// ---- bench/artwo_timer_monitor.sv ----
// checker for timer two register port and interrupt level
// assumes binding onto artwo_timer, one clock domain
`timescale 1ns/100ps
module artwo_timer_monitor
	import artwo_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       global_timer_irq_enable,
	input wire logic       irq
);
	// ------------------
	// access decodes
	// ------------------
	wire logic on_ctl = clk_en && sfr_addr == ADDR_CONTROL;
	wire logic on_rld = clk_en && sfr_addr[7:1] == 7'h65; // reload pair
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ------------------
	// properties
	// ------------------
	property p_spare_bits;
		on_ctl |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0;
	endproperty
	a_spare_bits: assert property (p_spare_bits)
		else $error("spare control bits not zero");
	property p_reload_back;
		(on_rld && sfr_wr) ##1 (clk_en && !sfr_wr && $stable(sfr_addr))
		|=> sfr_rdata == $past(sfr_wdata, 2);
	endproperty
	a_reload_back: assert property (p_reload_back)
		else $error("reload byte readback wrong");
	property p_ctl_back;
		(on_ctl && sfr_wr) ##1 (on_ctl && !sfr_wr)
		|=> (sfr_rdata & 8'h2d) == ($past(sfr_wdata, 2) & 8'h2d);
	endproperty
	a_ctl_back: assert property (p_ctl_back)
		else $error("control readback wrong");
	property p_reset_clear;
		$past(rst) |-> sfr_rdata == RESET_BYTE && !irq;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("state not clear after reset");
	property p_irq_gate;
		!global_timer_irq_enable |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without global enable");
	property p_flag_keep;
		on_ctl && $past(on_ctl) && !$past(sfr_wr) |=>
		(sfr_rdata[7:6] & $past(sfr_rdata[7:6])) == $past(sfr_rdata[7:6]);
	endproperty
	a_flag_keep: assert property (p_flag_keep)
		else $error("overflow flag dropped by itself");
	property p_irq_hold;
		irq && !sfr_wr && clk_en |=> irq || !global_timer_irq_enable;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped without write");
	property p_irq_flag;
		(on_ctl && $past(on_ctl) && !$past(sfr_wr) && !sfr_wr
		&& sfr_rdata[7]) ##1 global_timer_irq_enable |-> irq;
	endproperty
	a_irq_flag: assert property (p_irq_flag)
		else $error("high flag set but no interrupt");
endmodule : artwo_timer_monitor

bind artwo_timer artwo_timer_monitor artwo_timer_monitor_inst (
	.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.global_timer_irq_enable(global_timer_irq_enable), .irq(irq));

// ---- bench/tb_top.sv ----
// bench for timer two: registers, counting, flags, interrupt
// assumes artwo_timer and its checker, 25 MHz system clock
`timescale 1ns/100ps
module tb_top;
	import artwo_pkg::*;
	logic       clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, sfr_wr = 1'b0;
	logic       hi_sel = 1'b0, lo_sel = 1'b1, gie = 1'b1, ext_clk = 1'b0;
	logic       irq;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v;
	int         num_errors = 0, n_checks = 0;
	artwo_timer artwo_timer_inst (
		.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .high_byte_system_clock_select(hi_sel),
		.low_byte_system_clock_select(lo_sel), .global_timer_irq_enable(gie),
		.ext_clk(ext_clk), .irq(irq));
	// ------------------
	// clocks and access tasks
	// ------------------
	initial forever #20 clk_sys = ~clk_sys;
	always #80 ext_clk = ~ext_clk; // slow oscillator, off rising clk edges
	task automatic report_and_stop;
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk_sys);
		#1 sfr_wr = 1'b0;
		@(posedge clk_sys); // strobe low for one edge between writes
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		sfr_addr = a;
		repeat (2) @(posedge clk_sys);
		#1 q = sfr_rdata;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a, v);
		check(v, e);
	endtask : rc
	// run with control c for n cycles, then count at a within lo..hi
	task automatic rate(input logic [7:0] c, a, input int n, lo, hi);
		wr(a, 8'h00);
		wr(ADDR_CONTROL, c);
		idle(n);
		wr(ADDR_CONTROL, c & 8'hfb);
		rd(a, v);
		check({7'h00, v >= lo && v <= hi}, 8'h01);
	endtask : rate
	initial #2000000 begin
		num_errors++;
		report_and_stop();
	end
	// ------------------
	// main sequence
	// ------------------
	initial begin
		repeat (20) @(posedge clk_sys);
		#1 rst = 1'b0;
		rc(ADDR_CONTROL, RESET_BYTE);
		for (int i = 0; i < 4; i++) begin
			rc(ADDR_RELOAD_LOW + 8'(i), RESET_BYTE);
			wr(ADDR_RELOAD_LOW + 8'(i), 8'h5a + 8'(i));
			rc(ADDR_RELOAD_LOW + 8'(i), 8'h5a + 8'(i));
		end
		rc(8'hc9, 8'h00);
		wr(ADDR_CONTROL, 8'h12);
		rc(ADDR_CONTROL, 8'h00);
		wr(ADDR_CONTROL, 8'hc0);
		rc(ADDR_CONTROL, 8'hc0);
		check({7'h00, irq}, 8'h01);
		wr(ADDR_CONTROL, 8'h00);
		rc(ADDR_CONTROL, 8'h00);
		// 16-bit wrap from ffff with reload 1234
		wr(ADDR_RELOAD_HIGH, 8'h12);
		wr(ADDR_RELOAD_LOW, 8'h34);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_CONTROL, 8'h04);
		idle(8);
		rc(ADDR_COUNT_HIGH, 8'h12);
		rc(ADDR_CONTROL, 8'hc4);
		check({7'h00, irq}, 8'h01);
		gie = 1'b0;
		idle(1);
		check({7'h00, irq}, 8'h00);
		gie = 1'b1;
		wr(ADDR_CONTROL, 8'h24);
		check({7'h00, irq}, 8'h00);
		idle(220);
		rc(ADDR_CONTROL, 8'h64);
		check({7'h00, irq}, 8'h01);
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_COUNT_LOW, v);
		idle(20);
		rc(ADDR_COUNT_LOW, v);
		// count rates of each source
		lo_sel = 1'b0;
		rate(8'h04, ADDR_COUNT_LOW, 120, 9, 11);
		rate(8'h05, ADDR_COUNT_LOW, 320, 9, 11);
		rate(8'h0c, ADDR_COUNT_HIGH, 120, 9, 11);
		rate(8'h0d, ADDR_COUNT_HIGH, 320, 9, 11);
		hi_sel = 1'b1;
		rate(8'h0c, ADDR_COUNT_HIGH, 100, 98, 103);
		// split mode, low byte runs with run clear
		lo_sel = 1'b1;
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_RELOAD_LOW, 8'hf0);
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_CONTROL, 8'h08);
		idle(8);
		rc(ADDR_CONTROL, 8'h48);
		rc(ADDR_COUNT_HIGH, 8'hff);
		rd(ADDR_COUNT_LOW, v);
		check({7'h00, v >= 8'hf0}, 8'h01);
		check({7'h00, irq}, 8'h00);
		wr(ADDR_CONTROL, 8'h68);
		check({7'h00, irq}, 8'h01);
		wr(ADDR_CONTROL, 8'h0c);
		idle(4);
		rd(ADDR_CONTROL, v);
		check(v & 8'hbf, 8'h8c);
		check({7'h00, irq}, 8'h01);
		rd(ADDR_COUNT_HIGH, v);
		check({7'h00, v >= 8'h12 && v <= 8'h1a}, 8'h01);
		// clock enable low freezes the running high byte
		rd(ADDR_COUNT_HIGH, v);
		clk_en = 1'b0;
		idle(10);
		clk_en = 1'b1;
		rc(ADDR_COUNT_HIGH, v + 8'h02);
		wr(ADDR_CONTROL, 8'h00);
		report_and_stop();
	end
endmodule : tb_top
